// ### hdl/dpg_map.vh
// Register offsets, reset values and timing counts of the dual general-purpose port block.
`ifndef DPG_MAP_VH
`define DPG_MAP_VH
// ----------------------------------------------------------------
// Register byte offsets within the block
// ----------------------------------------------------------------
`define DPG_ADDR_W 6
`define DPG_OFF_BUS_DATA0 6'h11
`define DPG_OFF_BUS_DATA1 6'h13
`define DPG_OFF_BUS_DIR 6'h15
`define DPG_OFF_BUS_ASSIGN 6'h17
`define DPG_OFF_IRQ_DATA0 6'h19
`define DPG_OFF_IRQ_DATA1 6'h1b
`define DPG_OFF_IRQ_DIR 6'h1d
`define DPG_OFF_IRQ_ASSIGN 6'h1f
`define DPG_OFF_CONFIG 6'h21
`define DPG_OFF_STATUS 6'h23
// ----------------------------------------------------------------
// Reset values and strap positions
// ----------------------------------------------------------------
`define DPG_ASSIGN_ALL_ALT 8'hff
`define DPG_ASSIGN_ALL_IO 8'h00
`define DPG_DIR_RESET 8'h00
`define DPG_STRAP_BUS_BIT 8
`define DPG_STRAP_IRQ_BIT 9
// ----------------------------------------------------------------
// Reset pin stretch timing in output-clock cycles
// ----------------------------------------------------------------
`define DPG_RESET_HOLD_CYCLES 512
`define DPG_RESET_RELEASE_CYCLES 10
`endif

// ### hdl/dpg_ports.v
// Two eight-bit general-purpose ports with pin assignment, reset straps and register port.
`timescale 1ns/1ps
`include "dpg_map.vh"
// Contract
// - Data write latches; output pins drive latch.
// - Read gives pin for inputs, else latch.
// - Bus port latch at two aliases.
// - Irq port latch at two aliases.
// - Data latches keep contents through reset.
// - Direction one drives, zero is input.
// - Bus assign one selects bus control.
// - Bus assign bits map to bus signals.
// - Bus assign loads from strap bit 8.
// - Irq assign one selects alternate function.
// - Irq bits map to requests, clock mode.
// - Irq assign loads from strap bit 9.
// - Reset pin acts only on clock edges.
// - Synchronous reset waits for cycle end.
// - Asynchronous reset acts on any edge.
// - Reset overrides all, then configures.
// - Data straps pick boot width, pin functions.
// - Low straps swap chip selects for addresses.
// - Clock-mode strap picks clock source.
// - Breakpoint strap enables background debug.
// - Reset pin held 512 cycles after release.
module dpg_ports #(
    parameter HOLD_CYCLES = `DPG_RESET_HOLD_CYCLES,
    parameter RELEASE_CYCLES = `DPG_RESET_RELEASE_CYCLES
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Register port
    input wire [`DPG_ADDR_W-1:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [15:0] reg_rdata,
    // Reset pin and reset qualifiers
    input wire reset_pin_n_in,
    output reg reset_pin_n_out,
    output reg reset_pin_oe,
    input wire async_reset_kind,
    input wire bus_cycle_busy,
    output reg sys_reset,
    // Straps sampled during reset
    input wire [15:0] data_bus_in,
    input wire clock_source_select_pin,
    input wire breakpoint_pin,
    // Bus port pins
    input wire [7:0] bus_pin_in,
    output reg [7:0] bus_pin_out,
    output reg [7:0] bus_pin_oe,
    // Bus control functions routed to bus port pins, bit 7 down to 0:
    // transfer size hi, transfer size lo, address strobe, data strobe,
    // read-modify-write flag, autovector request, size ack hi, size ack lo.
    input wire [7:0] bus_ctl_out,
    input wire [7:0] bus_ctl_oe,
    output reg [7:0] bus_ctl_in,
    // Irq port pins
    input wire [7:0] irq_pin_in,
    output reg [7:0] irq_pin_out,
    output reg [7:0] irq_pin_oe,
    // Active-low interrupt requests 7 down to 1 from the irq port
    output reg [7:1] irq_request_n,
    // Captured configuration
    output reg boot_port_16bit,
    output reg chip_selects_0_2,
    output reg chip_selects_3_5,
    output reg [4:0] chip_select_keep,
    output reg use_internal_synth,
    output reg background_disabled
);
    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg [7:0] bus_data_reg;
    reg [7:0] bus_dir_reg;
    reg [7:0] bus_assign_reg;
    reg [7:0] irq_data_reg;
    reg [7:0] irq_dir_reg;
    reg [7:0] irq_assign_reg;
    wire sys_reset_w;
    wire pin_n_w;
    wire pin_oe_w;
    reg [15:0] rdata_next;

    // Pin read value: live pin for general I/O inputs, latch otherwise.
    function [7:0] port_read;
        input [7:0] latch;
        input [7:0] dir;
        input [7:0] assign_bits;
        input [7:0] pins;
        begin
            port_read = (pins & ~dir & ~assign_bits) | (latch & ~(~dir & ~assign_bits));
        end
    endfunction

    // ----------------------------------------------------------------
    // Reset controller
    // ----------------------------------------------------------------
    dpg_reset_ctl #(
        .HOLD_CYCLES(HOLD_CYCLES),
        .RELEASE_CYCLES(RELEASE_CYCLES)
    ) u_reset (
        .clock(clock),
        .rst(rst),
        .reset_pin_n_in(reset_pin_n_in),
        .reset_pin_n_out(pin_n_w),
        .reset_pin_oe(pin_oe_w),
        .async_reset_kind(async_reset_kind),
        .bus_cycle_busy(bus_cycle_busy),
        .sys_reset(sys_reset_w)
    );

    // Register the controller outputs so every port leaves a flip-flop.
    always @(posedge clock)
    begin
        if (rst)
        begin
            reset_pin_n_out <= 1'b0;
            reset_pin_oe <= 1'b1;
            sys_reset <= 1'b1;
        end
        else
        begin
            reset_pin_n_out <= pin_n_w;
            reset_pin_oe <= pin_oe_w;
            sys_reset <= sys_reset_w;
        end
    end

    // ----------------------------------------------------------------
    // Data latches: no reset, writable at any time
    // ----------------------------------------------------------------
    // Both aliases reach the same latch, also while a pin is alternate.
    always @(posedge clock)
    begin
        if (reg_write && (reg_addr == `DPG_OFF_BUS_DATA0 || reg_addr == `DPG_OFF_BUS_DATA1))
            bus_data_reg <= reg_wdata[7:0];
        if (reg_write && (reg_addr == `DPG_OFF_IRQ_DATA0 || reg_addr == `DPG_OFF_IRQ_DATA1))
            irq_data_reg <= reg_wdata[7:0];
    end

    // ----------------------------------------------------------------
    // Direction and assignment registers with strap loading
    // ----------------------------------------------------------------
    // While held in reset, assignment follows the data straps.
    always @(posedge clock)
    begin
        if (rst || sys_reset_w)
        begin
            bus_dir_reg <= `DPG_DIR_RESET;
            irq_dir_reg <= `DPG_DIR_RESET;
            bus_assign_reg <= `DPG_ASSIGN_ALL_IO;
            irq_assign_reg <= `DPG_ASSIGN_ALL_IO;
            if (!rst)
            begin
                bus_assign_reg <= data_bus_in[`DPG_STRAP_BUS_BIT] ? `DPG_ASSIGN_ALL_ALT : `DPG_ASSIGN_ALL_IO;
                irq_assign_reg <= data_bus_in[`DPG_STRAP_IRQ_BIT] ? `DPG_ASSIGN_ALL_ALT : `DPG_ASSIGN_ALL_IO;
            end
        end
        else if (reg_write)
        begin
            if (reg_addr == `DPG_OFF_BUS_DIR)
                bus_dir_reg <= reg_wdata[7:0];
            else if (reg_addr == `DPG_OFF_BUS_ASSIGN)
                bus_assign_reg <= reg_wdata[7:0];
            else if (reg_addr == `DPG_OFF_IRQ_DIR)
                irq_dir_reg <= reg_wdata[7:0];
            else if (reg_addr == `DPG_OFF_IRQ_ASSIGN)
                irq_assign_reg <= reg_wdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Configuration straps
    // ----------------------------------------------------------------
    // Sampled every cycle of reset; the last sample before release stays.
    always @(posedge clock)
    begin
        if (rst)
        begin
            boot_port_16bit <= 1'b1;
            chip_selects_0_2 <= 1'b1;
            chip_selects_3_5 <= 1'b1;
            chip_select_keep <= 5'h1f;
            use_internal_synth <= 1'b1;
            background_disabled <= 1'b1;
        end
        else if (sys_reset_w)
        begin
            boot_port_16bit <= data_bus_in[0];
            chip_selects_0_2 <= data_bus_in[1];
            chip_selects_3_5 <= data_bus_in[2];
            // A low strap turns its own chip select and every lower one into address lines.
            chip_select_keep <= {data_bus_in[7],
                                 data_bus_in[7] & data_bus_in[6],
                                 data_bus_in[7] & data_bus_in[6] & data_bus_in[5],
                                 data_bus_in[7] & data_bus_in[6] & data_bus_in[5] & data_bus_in[4],
                                 data_bus_in[7] & data_bus_in[6] & data_bus_in[5] & data_bus_in[4] & data_bus_in[3]};
            use_internal_synth <= clock_source_select_pin;
            background_disabled <= breakpoint_pin;
        end
    end

    // ----------------------------------------------------------------
    // Pin drive and alternate-function routing
    // ----------------------------------------------------------------
    // Alternate bus pins take the bus control drive, alternate irq pins are undriven; direction and latch are ignored.
    always @(posedge clock)
    begin
        if (rst || sys_reset_w)
        begin
            bus_pin_out <= 8'h00;
            bus_pin_oe <= 8'h00;
            irq_pin_out <= 8'h00;
            irq_pin_oe <= 8'h00;
            bus_ctl_in <= 8'hff;
            irq_request_n <= 7'h7f;
        end
        else
        begin
            bus_pin_out <= (bus_assign_reg & bus_ctl_out) | (~bus_assign_reg & bus_data_reg);
            bus_pin_oe <= (bus_assign_reg & bus_ctl_oe) | (~bus_assign_reg & bus_dir_reg);
            bus_ctl_in <= bus_pin_in | ~bus_assign_reg;
            irq_pin_out <= ~irq_assign_reg & irq_data_reg;
            irq_pin_oe <= ~irq_assign_reg & irq_dir_reg;
            // Bit 0 is the clock-mode input and has no use once running.
            irq_request_n <= irq_pin_in[7:1] | ~irq_assign_reg[7:1];
        end
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    // Address decode; unmapped addresses read as zero.
    always @*
    begin
        rdata_next = 16'h0000;
        if (reg_addr == `DPG_OFF_BUS_DATA0 || reg_addr == `DPG_OFF_BUS_DATA1)
            rdata_next[7:0] = port_read(bus_data_reg, bus_dir_reg, bus_assign_reg, bus_pin_in);
        else if (reg_addr == `DPG_OFF_BUS_DIR)
            rdata_next[7:0] = bus_dir_reg;
        else if (reg_addr == `DPG_OFF_BUS_ASSIGN)
            rdata_next[7:0] = bus_assign_reg;
        else if (reg_addr == `DPG_OFF_IRQ_DATA0 || reg_addr == `DPG_OFF_IRQ_DATA1)
            rdata_next[7:0] = port_read(irq_data_reg, irq_dir_reg, irq_assign_reg, irq_pin_in);
        else if (reg_addr == `DPG_OFF_IRQ_DIR)
            rdata_next[7:0] = irq_dir_reg;
        else if (reg_addr == `DPG_OFF_IRQ_ASSIGN)
            rdata_next[7:0] = irq_assign_reg;
        else if (reg_addr == `DPG_OFF_CONFIG)
            rdata_next[9:0] = {background_disabled, use_internal_synth, chip_select_keep,
                               chip_selects_3_5, chip_selects_0_2, boot_port_16bit};
        else if (reg_addr == `DPG_OFF_STATUS)
            rdata_next[1:0] = {reset_pin_oe, sys_reset};
    end

    // Read data stands in the cycle after the strobe only.
    always @(posedge clock)
    begin
        if (rst)
            reg_rdata <= 16'h0000;
        else if (reg_read)
            reg_rdata <= rdata_next;
        else
            reg_rdata <= 16'h0000;
    end
endmodule

// ### hdl/dpg_reset_ctl.v
// Reset capture, bus-cycle deferral and reset pin stretching for the port block.
`timescale 1ns/1ps
`include "dpg_map.vh"
module dpg_reset_ctl #(
    parameter HOLD_CYCLES = `DPG_RESET_HOLD_CYCLES,
    parameter RELEASE_CYCLES = `DPG_RESET_RELEASE_CYCLES
) (
    // Clock and power-up reset
    input wire clock,
    input wire rst,
    // Reset pin, sampled level and drive
    input wire reset_pin_n_in,
    output reg reset_pin_n_out,
    output reg reset_pin_oe,
    // Reset kind and bus-cycle boundary
    input wire async_reset_kind,
    input wire bus_cycle_busy,
    // Internal reset level to the block
    output reg sys_reset
);
    localparam ST_RUN = 2'd0;
    localparam ST_HOLD = 2'd1;
    localparam ST_FLOAT = 2'd2;
    reg [1:0] state_reg;
    reg [9:0] count_reg;
    // Reset pin is only seen on clock edges; no clock means no reset.
    always @(posedge clock)
    begin
        if (rst)
        begin
            state_reg <= ST_HOLD;
            count_reg <= 10'h000;
            sys_reset <= 1'b1;
            reset_pin_n_out <= 1'b0;
            reset_pin_oe <= 1'b1;
        end
        else
        begin
            case (state_reg)
                ST_RUN:
                begin
                    // A catastrophic reset acts at once; otherwise wait for the cycle end.
                    if (!reset_pin_n_in && (async_reset_kind || !bus_cycle_busy))
                    begin
                        state_reg <= ST_HOLD;
                        count_reg <= 10'h000;
                        sys_reset <= 1'b1;
                        reset_pin_oe <= 1'b1;
                    end
                end
                ST_HOLD:
                begin
                    // Keep the pin low while held externally, then a further fixed count.
                    if (!reset_pin_n_in)
                        count_reg <= 10'h000;
                    else if (count_reg == HOLD_CYCLES[9:0] - 10'h001)
                    begin
                        state_reg <= ST_FLOAT;
                        count_reg <= 10'h000;
                        reset_pin_oe <= 1'b0;
                    end
                    else
                        count_reg <= count_reg + 10'h001;
                end
                default:
                begin
                    // Let the pin float, then test it once before leaving reset.
                    if (count_reg == RELEASE_CYCLES[9:0] - 10'h001)
                    begin
                        count_reg <= 10'h000;
                        if (reset_pin_n_in)
                        begin
                            state_reg <= ST_RUN;
                            sys_reset <= 1'b0;
                        end
                        else
                        begin
                            state_reg <= ST_HOLD;
                            reset_pin_oe <= 1'b1;
                        end
                    end
                    else
                        count_reg <= count_reg + 10'h001;
                end
            endcase
        end
    end
endmodule

// ### tb/dpg_board.sv
// Board model: resolves both ports' pins from the block's drivers and the board levels.
`timescale 1ns/1ps
module dpg_board (
    // Block drivers
    input wire [7:0] bus_pin_out,
    input wire [7:0] bus_pin_oe,
    input wire [7:0] irq_pin_out,
    input wire [7:0] irq_pin_oe,
    // Board levels on undriven pins
    input wire [7:0] bus_level,
    input wire [7:0] irq_level,
    // Resolved pin levels back to the block
    output wire [7:0] bus_pin_in,
    output wire [7:0] irq_pin_in
);
    // A driven pin shows the block's bit, any other the board level.
    assign bus_pin_in = (bus_pin_oe & bus_pin_out) | (~bus_pin_oe & bus_level);
    assign irq_pin_in = (irq_pin_oe & irq_pin_out) | (~irq_pin_oe & irq_level);
endmodule

// ### tb/dpg_ports_properties.sv
// Concurrent checks on the top-level pins of the dual port block.
`timescale 1ns/1ps
module dpg_ports_checker #(
    parameter HOLD_CYCLES = 512,
    parameter RELEASE_CYCLES = 10
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Register read path
    input wire reg_read,
    input wire [15:0] reg_rdata,
    // Reset pin and qualifiers
    input wire reset_pin_n_in,
    input wire reset_pin_n_out,
    input wire reset_pin_oe,
    input wire async_reset_kind,
    input wire bus_cycle_busy,
    input wire sys_reset,
    // Port pins
    input wire [7:0] bus_pin_oe,
    input wire [7:0] irq_pin_oe,
    input wire [7:0] bus_ctl_in,
    input wire [7:1] irq_request_n
);
    reg [9:0] high_run_reg;
    reg [9:0] float_run_reg;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Saturating run lengths of a released reset pin and of a floating pin driver.
    always @(posedge clock)
    begin
        if (rst || !reset_pin_n_in) high_run_reg <= 10'h000;
        else if (high_run_reg != 10'h3ff) high_run_reg <= high_run_reg + 10'h001;
        if (rst || reset_pin_oe) float_run_reg <= 10'h000;
        else if (float_run_reg != 10'h3ff) float_run_reg <= float_run_reg + 10'h001;
    end
    // A reset request arriving while a bus cycle is open must wait for its end.
    sequence s_busy_run;
        (!sys_reset && bus_cycle_busy && !async_reset_kind) [*2];
    endsequence
    sequence s_sync_take;
        !reset_pin_n_in && !bus_cycle_busy && !async_reset_kind;
    endsequence
    a_read_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside the answer cycle");
    a_upper_read_zero: assert property ($past(reg_read) |-> reg_rdata[15:8] == 8'h00)
        else $error("upper read byte not zero");
    a_reset_pin_low: assert property (reset_pin_oe |-> !reset_pin_n_out)
        else $error("reset pin driven high");
    a_reset_forces_state: assert property ($fell(rst) |-> sys_reset && reset_pin_oe && bus_pin_oe == 8'h00
        && irq_pin_oe == 8'h00 && bus_ctl_in == 8'hff && irq_request_n == 7'h7f)
        else $error("state after reset wrong");
    a_hold_before_float: assert property ($fell(reset_pin_oe) |-> high_run_reg >= HOLD_CYCLES)
        else $error("reset pin released too early");
    a_float_before_run: assert property ($fell(sys_reset) |-> float_run_reg >= RELEASE_CYCLES)
        else $error("reset left before float period");
    a_sync_deferred: assert property (s_busy_run |=> !sys_reset)
        else $error("reset acted inside a bus cycle");
    a_sync_taken: assert property (s_sync_take |-> ##2 sys_reset)
        else $error("sampled reset not taken");
    a_async_taken: assert property (!reset_pin_n_in && async_reset_kind |-> ##2 sys_reset)
        else $error("catastrophic reset not taken");
endmodule
bind dpg_ports dpg_ports_checker #(.HOLD_CYCLES(HOLD_CYCLES), .RELEASE_CYCLES(RELEASE_CYCLES)) chk_u (
    .clock(clock), .rst(rst), .reg_read(reg_read), .reg_rdata(reg_rdata), .reset_pin_n_in(reset_pin_n_in),
    .reset_pin_n_out(reset_pin_n_out), .reset_pin_oe(reset_pin_oe), .async_reset_kind(async_reset_kind),
    .bus_cycle_busy(bus_cycle_busy), .sys_reset(sys_reset), .bus_pin_oe(bus_pin_oe), .irq_pin_oe(irq_pin_oe),
    .bus_ctl_in(bus_ctl_in), .irq_request_n(irq_request_n));

// ### tb/dpg_ports_test.sv
// Register-level testbench of the dual port block with reset straps.
`timescale 1ns/1ps
`include "dpg_map.vh"
module dpg_ports_test;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [5:0] reg_addr = 6'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic reset_n_ext = 1'b1;
    logic async_reset_kind = 1'b0;
    logic bus_cycle_busy = 1'b0;
    logic [15:0] data_bus_in = 16'h01a5;
    logic clock_source_select_pin = 1'b0;
    logic breakpoint_pin = 1'b1;
    logic [7:0] bus_ctl_out = 8'h96;
    logic [7:0] bus_ctl_oe = 8'h0f;
    logic [7:0] bus_level = 8'h81;
    logic [7:0] irq_level = 8'h3c;
    wire [15:0] reg_rdata;
    wire [7:0] bus_pin_in, bus_pin_out, bus_pin_oe, bus_ctl_in, irq_pin_in, irq_pin_out, irq_pin_oe;
    wire [7:1] irq_request_n;
    wire [4:0] chip_select_keep;
    wire reset_pin_n_out, reset_pin_oe, sys_reset, boot_port_16bit, chip_selects_0_2, chip_selects_3_5;
    wire use_internal_synth, background_disabled;
    int n_errors = 0;
    int checks = 0;
    // Short hold counts keep each reset stretch to about a dozen cycles.
    dpg_ports #(.HOLD_CYCLES(8), .RELEASE_CYCLES(3)) dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .reset_pin_n_in(reset_n_ext), .reset_pin_n_out(reset_pin_n_out), .reset_pin_oe(reset_pin_oe),
        .async_reset_kind(async_reset_kind), .bus_cycle_busy(bus_cycle_busy), .sys_reset(sys_reset),
        .data_bus_in(data_bus_in), .clock_source_select_pin(clock_source_select_pin),
        .breakpoint_pin(breakpoint_pin), .bus_pin_in(bus_pin_in), .bus_pin_out(bus_pin_out),
        .bus_pin_oe(bus_pin_oe), .bus_ctl_out(bus_ctl_out), .bus_ctl_oe(bus_ctl_oe), .bus_ctl_in(bus_ctl_in),
        .irq_pin_in(irq_pin_in), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe),
        .irq_request_n(irq_request_n), .boot_port_16bit(boot_port_16bit), .chip_selects_0_2(chip_selects_0_2),
        .chip_selects_3_5(chip_selects_3_5), .chip_select_keep(chip_select_keep),
        .use_internal_synth(use_internal_synth), .background_disabled(background_disabled));
    // The reset pin input sees the board side, so the release can be detected while driven.
    dpg_board board_u (.bus_pin_out(bus_pin_out), .bus_pin_oe(bus_pin_oe), .irq_pin_out(irq_pin_out),
        .irq_pin_oe(irq_pin_oe), .bus_level(bus_level), .irq_level(irq_level), .bus_pin_in(bus_pin_in),
        .irq_pin_in(irq_pin_in));
    // Clock of 25 MHz.
    always #20 clock = ~clock;
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask
    // Upper write byte is set so that ignoring it is exercised on every write.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= {8'hff, d};
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk("read data", {8'h00, exp}, reg_rdata);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Waits, bounded, for the block to leave reset.
    task automatic wait_free();
        for (int i = 0; i < 200 && sys_reset !== 1'b0; i++)
            settle(1);
        if (sys_reset !== 1'b0)
        begin
            $display("[FAIL] reset release timed out");
            n_errors++;
            wrap_up();
        end
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        settle(20);
        rst <= 1'b0;
        wait_free();
        chk("config a", 16'h002b, {10'h000, boot_port_16bit, chip_selects_0_2, chip_selects_3_5, use_internal_synth,
            background_disabled, 1'b1});
        chk("cs keep a", 16'h0010, {11'h000, chip_select_keep});
        rd(`DPG_OFF_STATUS, 8'h00);
        rd(`DPG_OFF_BUS_ASSIGN, 8'hff);
        rd(`DPG_OFF_IRQ_ASSIGN, 8'h00);
        rd(`DPG_OFF_BUS_DIR, 8'h00);
        rd(6'h01, 8'h00);
        wr(6'h00, 8'h5a);
        rd(6'h00, 8'h00);
        wr(`DPG_OFF_BUS_DATA0, 8'h3c);
        wr(`DPG_OFF_BUS_DIR, 8'hff);
        settle(3);
        chk("bus oe alt", 16'h000f, {8'h00, bus_pin_oe});
        chk("bus out alt", 16'h0006, {8'h00, bus_pin_out & bus_pin_oe});
        chk("bus ctl in", {8'h00, bus_pin_in}, {8'h00, bus_ctl_in});
        rd(`DPG_OFF_BUS_DATA1, 8'h3c);
        wr(`DPG_OFF_BUS_ASSIGN, 8'h0f);
        wr(`DPG_OFF_BUS_DIR, 8'h50);
        settle(3);
        chk("bus oe mixed", 16'h005f, {8'h00, bus_pin_oe});
        chk("bus out mixed", 16'h0016, {8'h00, bus_pin_out & bus_pin_oe});
        rd(`DPG_OFF_BUS_DATA0, 8'h9c);
        wr(`DPG_OFF_IRQ_DATA1, 8'ha5);
        wr(`DPG_OFF_IRQ_DIR, 8'h0f);
        settle(3);
        chk("irq oe io", 16'h000f, {8'h00, irq_pin_oe});
        chk("irq out io", 16'h0005, {8'h00, irq_pin_out & irq_pin_oe});
        chk("irq req io", 16'h007f, {9'h000, irq_request_n});
        rd(`DPG_OFF_IRQ_DATA0, 8'h35);
        wr(`DPG_OFF_IRQ_ASSIGN, 8'hf1);
        settle(3);
        chk("irq oe alt", 16'h000e, {8'h00, irq_pin_oe});
        chk("irq req alt", 16'h001f, {9'h000, irq_request_n});
        rd(`DPG_OFF_IRQ_DATA1, 8'ha5);
        // Reset requested inside an open bus cycle, then let through; straps flipped.
        reset_n_ext <= 1'b0;
        bus_cycle_busy <= 1'b1;
        data_bus_in <= 16'h0200;
        clock_source_select_pin <= 1'b1;
        breakpoint_pin <= 1'b0;
        settle(5);
        chk("deferred", 16'h0000, {15'h0000, sys_reset});
        bus_cycle_busy <= 1'b0;
        settle(3);
        chk("taken", 16'h0001, {15'h0000, sys_reset});
        reset_n_ext <= 1'b1;
        wait_free();
        chk("config b", 16'h0005, {10'h000, boot_port_16bit, chip_selects_0_2, chip_selects_3_5, use_internal_synth,
            background_disabled, 1'b1});
        chk("cs keep b", 16'h0000, {11'h000, chip_select_keep});
        rd(`DPG_OFF_BUS_ASSIGN, 8'h00);
        rd(`DPG_OFF_IRQ_ASSIGN, 8'hff);
        chk("irq req strap", 16'h001e, {9'h000, irq_request_n});
        rd(`DPG_OFF_IRQ_DATA0, 8'ha5);
        // Catastrophic reset acts even inside a bus cycle.
        async_reset_kind <= 1'b1;
        bus_cycle_busy <= 1'b1;
        reset_n_ext <= 1'b0;
        settle(3);
        chk("async taken", 16'h0001, {15'h0000, sys_reset});
        reset_n_ext <= 1'b1;
        async_reset_kind <= 1'b0;
        bus_cycle_busy <= 1'b0;
        wait_free();
        rd(`DPG_OFF_IRQ_DATA1, 8'ha5);
        wrap_up();
    end
endmodule
